// >>> cgm_gate_mode_logic.sv
// Overview of operation
// RULE1 - Bits 4 and 3 of the mode word select how gate edges act while gating is enabled.
// RULE2 - Behaviour 0 starts counting on one qualifying edge and halts on the next.
// RULE3 - Behaviour 1 halts counting on the first qualifying edge and resumes on the second.
// RULE4 - Behaviour 2 lets every qualifying edge only start counting; terminal count stops it.
// RULE5 - Behaviour 3 makes gate edges neither start nor stop counting.
// RULE6 - Software picks behaviours 0 or 1 only with the stop selection at 0.
// RULE7 - Software uses behaviours 0 to 2 only with edge or level gating.
// RULE8 - Bit 2 with rising-edge gating makes both gate transitions qualify.
// RULE9 - Bits 1 and 0 decode to off, level, rising-edge and falling-edge gating.
// RULE10 - Gate inversion is applied before edge detection and so swaps the active edge.
// RULE11 - With gating off the gate never qualifies counting and only offers a direction level.
// RULE12 - The stop selection picks gate only, gate or first count, gate or second count.
// RULE13 - Edges come from comparing the registered adjusted gate level with its last sample.
//
// Design decision made here: the APB register port.
module cgm_gate_mode_logic (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic [11:0]            paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  input  wire logic                   gate_in,
  input  wire logic                   terminal_count,
  output logic                        count_enable,
  output logic                        gate_edge,
  output logic                        direction_gate,
  output cgm_pkg::cgm_alt_gate_t      alt_gate_cfg
);

  `include "cgm_map.svh"

  logic [15:0]            mode_reg;
  logic [15:0]            mode_next;
  cgm_pkg::cgm_alt_gate_t alt_reg;
  cgm_pkg::cgm_alt_gate_t alt_next;
  logic [31:0]            rdata_reg;
  logic [31:0]            rdata_next;
  cgm_pkg::cgm_state_t    state_reg;
  cgm_pkg::cgm_state_t    state_next;
  logic                   count_reg;
  logic                   count_next;
  logic                   qual_reg;
  logic                   qual_next;
  cgm_pkg::cgm_mode_t     mode;
  cgm_pkg::cgm_edges_t    edges;
  logic                   access;
  logic                   wr_access;
  logic                   mapped;
  logic                   arm_cmd;
  logic                   disarm_cmd;
  logic                   qual;
  logic                   tc_stop;
  logic                   tc_pending;
  logic                   restart;

  // Splits a raw mode word into its fields.
  function automatic cgm_pkg::cgm_mode_t decode_mode(input logic [15:0] w);
    cgm_pkg::cgm_mode_t m;
    m.gate_invert            = w[`CGM_MODE_INV_BIT];
    m.hw_stop_select         = cgm_pkg::cgm_stop_t'(w[`CGM_MODE_STOP_HI:`CGM_MODE_STOP_LO]);
    m.edge_trigger_behaviour = cgm_pkg::cgm_etb_t'(w[`CGM_MODE_ETB_HI:`CGM_MODE_ETB_LO]); // [RULE1]
    m.dual_edge_gating       = w[`CGM_MODE_DUAL_BIT];
    m.gate_interpretation    =
      cgm_pkg::cgm_interp_t'(w[`CGM_MODE_INTERP_HI:`CGM_MODE_INTERP_LO]); // [RULE9]
    return m;
  endfunction

  // True when the address hits one of the block's registers.
  function automatic logic addr_hit(input logic [11:0] a);
    logic hit;
    hit = 1'b0;
    if (a == `CGM_MODE_OFFSET) begin
      hit = 1'b1;
    end else if (a == `CGM_ALT_GATE_OFFSET) begin
      hit = 1'b1;
    end else if (a == `CGM_STATUS_OFFSET) begin
      hit = 1'b1;
    end else if (a == `CGM_CONTROL_OFFSET) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // Picks the gate edges that qualify under the current interpretation.
  function automatic logic qual_edge(input cgm_pkg::cgm_mode_t m,
                                     input cgm_pkg::cgm_edges_t e);
    logic q;
    q = 1'b0;
    case (m.gate_interpretation)
      cgm_pkg::CGM_GATE_RISE: begin
        q = e.rise | (m.dual_edge_gating & e.fall);    // [RULE8]
      end
      cgm_pkg::CGM_GATE_FALL: begin
        q = e.fall;                                     // [RULE9]
      end
      default: begin
        q = 1'b0;                                       // [RULE11]
      end
    endcase
    return q;
  endfunction

  assign mode = decode_mode(mode_reg);

  cgm_gate_edge u_gate_edge (
    .pclk        (pclk),
    .presetn     (presetn),
    .gate_in     (gate_in),
    .gate_invert (mode.gate_invert),
    .edges       (edges)
  );

  cgm_tc_stop u_tc_stop (
    .pclk           (pclk),
    .presetn        (presetn),
    .hw_stop_select (mode.hw_stop_select),
    .counting       (count_reg),
    .terminal_count (terminal_count),
    .restart        (restart),
    .tc_stop        (tc_stop),
    .tc_pending     (tc_pending)
  );

  // Bus decode: zero wait states, unmapped addresses answer with an error.
  always_comb begin
    access     = psel & penable;
    mapped     = addr_hit(paddr);
    wr_access  = access & pwrite & mapped;
    arm_cmd    = 1'b0;
    disarm_cmd = 1'b0;
    if (wr_access && paddr == `CGM_CONTROL_OFFSET) begin
      arm_cmd    = pwdata[`CGM_CTRL_ARM_BIT];
      disarm_cmd = pwdata[`CGM_CTRL_DISARM_BIT];
    end
  end

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // Register writes; the mode and second gate words are write-only.
  always_comb begin
    mode_next  = mode_reg;
    alt_next   = alt_reg;
    rdata_next = rdata_reg;
    if (wr_access && paddr == `CGM_MODE_OFFSET) begin
      mode_next = pwdata[15:0];
    end else if (wr_access && paddr == `CGM_ALT_GATE_OFFSET) begin
      alt_next.alt_gate_invert  = pwdata[`CGM_ALT_INV_BIT];
      alt_next.alt_gate_source  = pwdata[`CGM_ALT_SRC_HI:`CGM_ALT_SRC_LO];
      alt_next.second_gate_mode = pwdata[`CGM_ALT_MODE_BIT];
    end
    if (psel && !penable && !pwrite) begin
      rdata_next = `CGM_RDATA_RESET;
      if (paddr == `CGM_STATUS_OFFSET) begin
        rdata_next[`CGM_STAT_COUNT_BIT] = count_reg;
        rdata_next[`CGM_STAT_ARMED_BIT] = (state_reg != cgm_pkg::CGM_ST_DISARMED);
        rdata_next[`CGM_STAT_LEVEL_BIT] = edges.level;
        rdata_next[`CGM_STAT_TC_BIT]    = tc_pending;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg  <= `CGM_MODE_RESET;
      alt_reg   <= `CGM_ALT_RESET;
      rdata_reg <= `CGM_RDATA_RESET;
    end else begin
      mode_reg  <= mode_next;
      alt_reg   <= alt_next;
      rdata_reg <= rdata_next;
    end
  end

  assign prdata       = rdata_reg;
  assign alt_gate_cfg = alt_reg;

  // Run state: disarmed, armed and waiting for a start, or counting.
  always_comb begin
    qual       = qual_edge(mode, edges);
    state_next = state_reg;
    restart    = 1'b0;
    case (state_reg)
      cgm_pkg::CGM_ST_DISARMED: begin
        if (arm_cmd) begin
          restart = 1'b1;
          if (mode.gate_interpretation == cgm_pkg::CGM_GATE_OFF ||
              mode.gate_interpretation == cgm_pkg::CGM_GATE_LEVEL) begin
            state_next = cgm_pkg::CGM_ST_COUNT;                  // [RULE11]
          end else if (mode.edge_trigger_behaviour == cgm_pkg::CGM_ETB_STOP_START ||
                       mode.edge_trigger_behaviour == cgm_pkg::CGM_ETB_NONE) begin
            state_next = cgm_pkg::CGM_ST_COUNT;                  // [RULE3] [RULE5]
          end else begin
            state_next = cgm_pkg::CGM_ST_WAIT;                   // [RULE2] [RULE4]
          end
        end
      end
      cgm_pkg::CGM_ST_WAIT: begin
        if (qual && mode.edge_trigger_behaviour != cgm_pkg::CGM_ETB_NONE) begin
          state_next = cgm_pkg::CGM_ST_COUNT;                    // [RULE2] [RULE3] [RULE4]
          restart    = 1'b1;
        end
      end
      cgm_pkg::CGM_ST_COUNT: begin
        if (tc_stop) begin
          state_next = cgm_pkg::CGM_ST_WAIT;                     // [RULE12] [RULE4]
        end else if (qual &&
                     (mode.edge_trigger_behaviour == cgm_pkg::CGM_ETB_START_STOP ||
                      mode.edge_trigger_behaviour == cgm_pkg::CGM_ETB_STOP_START)) begin
          state_next = cgm_pkg::CGM_ST_WAIT;                     // [RULE2] [RULE3]
        end
      end
      default: begin
        state_next = cgm_pkg::CGM_ST_DISARMED;
      end
    endcase
    if (disarm_cmd) begin
      state_next = cgm_pkg::CGM_ST_DISARMED;
    end
  end

  // Level gating qualifies counting by the adjusted level; behaviour 3 ignores it.
  always_comb begin
    count_next = (state_next == cgm_pkg::CGM_ST_COUNT);
    if (mode.gate_interpretation == cgm_pkg::CGM_GATE_LEVEL &&
        mode.edge_trigger_behaviour != cgm_pkg::CGM_ETB_NONE) begin
      count_next = count_next & edges.level;                     // [RULE9]
    end
    qual_next = qual;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= cgm_pkg::CGM_ST_DISARMED;
      count_reg <= 1'b0;
      qual_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      qual_reg  <= qual_next;
    end
  end

  assign count_enable   = count_reg;
  assign gate_edge      = qual_reg;
  assign direction_gate = edges.level;                           // [RULE11]

endmodule

// >>> cgm_map.svh
`ifndef CGM_MAP_SVH
`define CGM_MAP_SVH

// Register byte offsets on the APB bus.
`define CGM_MODE_OFFSET     12'h0B0
`define CGM_ALT_GATE_OFFSET 12'h0B4
`define CGM_STATUS_OFFSET   12'h0B8
`define CGM_CONTROL_OFFSET  12'h0BC

// Counter mode control word fields.
`define CGM_MODE_INV_BIT    13
`define CGM_MODE_STOP_HI    6
`define CGM_MODE_STOP_LO    5
`define CGM_MODE_ETB_HI     4
`define CGM_MODE_ETB_LO     3
`define CGM_MODE_DUAL_BIT   2
`define CGM_MODE_INTERP_HI  1
`define CGM_MODE_INTERP_LO  0

// Second gate control word fields.
`define CGM_ALT_INV_BIT     13
`define CGM_ALT_SRC_HI      11
`define CGM_ALT_SRC_LO      7
`define CGM_ALT_MODE_BIT    0

// Control register command bits.
`define CGM_CTRL_ARM_BIT    0
`define CGM_CTRL_DISARM_BIT 1

// Status register bits.
`define CGM_STAT_COUNT_BIT  0
`define CGM_STAT_ARMED_BIT  1
`define CGM_STAT_LEVEL_BIT  2
`define CGM_STAT_TC_BIT     3

// Reset values.
`define CGM_MODE_RESET      16'h0000
`define CGM_ALT_RESET       7'h00
`define CGM_RDATA_RESET     32'h00000000

`endif

// >>> cgm_pkg.sv
package cgm_pkg;

  typedef enum logic [1:0] {
    CGM_GATE_OFF   = 2'b00,
    CGM_GATE_LEVEL = 2'b01,
    CGM_GATE_RISE  = 2'b10,
    CGM_GATE_FALL  = 2'b11
  } cgm_interp_t;

  typedef enum logic [1:0] {
    CGM_ETB_START_STOP = 2'b00,
    CGM_ETB_STOP_START = 2'b01,
    CGM_ETB_START_ONLY = 2'b10,
    CGM_ETB_NONE       = 2'b11
  } cgm_etb_t;

  typedef enum logic [1:0] {
    CGM_STOP_GATE = 2'b00,
    CGM_STOP_TC1  = 2'b01,
    CGM_STOP_TC2  = 2'b10,
    CGM_STOP_RSVD = 2'b11
  } cgm_stop_t;

  typedef enum logic [1:0] {
    CGM_ST_DISARMED = 2'b00,
    CGM_ST_WAIT     = 2'b01,
    CGM_ST_COUNT    = 2'b10
  } cgm_state_t;

  typedef struct packed {
    logic        gate_invert;
    cgm_stop_t   hw_stop_select;
    cgm_etb_t    edge_trigger_behaviour;
    logic        dual_edge_gating;
    cgm_interp_t gate_interpretation;
  } cgm_mode_t;

  typedef struct packed {
    logic       alt_gate_invert;
    logic [4:0] alt_gate_source;
    logic       second_gate_mode;
  } cgm_alt_gate_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } cgm_edges_t;

endpackage

// >>> cgm_gate_edge.sv
// Samples the gate after polarity adjustment and reports its edges.
module cgm_gate_edge (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               gate_in,
  input  wire logic               gate_invert,
  output cgm_pkg::cgm_edges_t     edges
);

  logic               level_reg;
  logic               level_next;
  logic               prev_reg;
  logic               prev_next;
  cgm_pkg::cgm_edges_t edges_reg;
  cgm_pkg::cgm_edges_t edges_next;

  always_comb begin
    level_next       = gate_in ^ gate_invert;     // [RULE10]
    prev_next        = level_reg;
    edges_next.level = level_reg;
    edges_next.rise  = level_reg & ~prev_reg;     // [RULE13]
    edges_next.fall  = ~level_reg & prev_reg;     // [RULE13]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg <= 1'b0;
      prev_reg  <= 1'b0;
      edges_reg <= '0;
    end else begin
      level_reg <= level_next;
      prev_reg  <= prev_next;
      edges_reg <= edges_next;
    end
  end

  assign edges = edges_reg;

endmodule

// >>> cgm_tc_stop.sv
// Decides when terminal count halts counting, per the stop selection.
module cgm_tc_stop (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire cgm_pkg::cgm_stop_t hw_stop_select,
  input  wire logic               counting,
  input  wire logic               terminal_count,
  input  wire logic               restart,
  output logic                    tc_stop,
  output logic                    tc_pending
);

  logic seen_reg;
  logic seen_next;
  logic tc_hit;

  always_comb begin
    tc_hit    = counting & terminal_count;
    tc_stop   = 1'b0;
    seen_next = seen_reg;
    case (hw_stop_select)
      cgm_pkg::CGM_STOP_TC1: begin
        tc_stop = tc_hit;                                    // [RULE12]
      end
      cgm_pkg::CGM_STOP_TC2: begin
        tc_stop = tc_hit & seen_reg;                         // [RULE12]
        if (tc_hit) begin
          seen_next = ~seen_reg;
        end
      end
      default: begin
        tc_stop = 1'b0;                                      // [RULE12]
      end
    endcase
    if (restart) begin
      seen_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_reg <= 1'b0;
    end else begin
      seen_reg <= seen_next;
    end
  end

  assign tc_pending = seen_reg;

endmodule

// >>> cgm_gate_mode_logic_monitor.sv
module cgm_gate_mode_logic_monitor (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic [11:0]            paddr,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [31:0]            pwdata,
  input wire logic                   pready,
  input wire logic [31:0]            prdata,
  input wire logic                   pslverr,
  input wire logic                   gate_in,
  input wire logic                   terminal_count,
  input wire logic                   count_enable,
  input wire logic                   gate_edge,
  input wire logic                   direction_gate,
  input wire cgm_pkg::cgm_alt_gate_t alt_gate_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shadow of the write-only mode word, packed as {invert, stop, behaviour, dual, interp}.
  logic [7:0] md;
  logic       arm;
  logic [2:0] qc;
  logic       wr;
  assign wr = psel && penable && pwrite;
  // The quiet count keeps the gate edge checks off while a new mode or arm command settles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      md  <= 8'h00;
      arm <= 1'b0;
      qc  <= 3'h0;
    end else begin
      if (wr && paddr == 12'h0B0) begin
        md <= {pwdata[13], pwdata[6:0]};
      end
      if (wr && paddr == 12'h0BC) begin
        arm <= !pwdata[1] && (pwdata[0] || arm);
      end
      qc <= (wr && paddr[11:4] == 8'h0B) ? 3'h0 : ((qc == 3'h7) ? qc : qc + 3'h1);
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire q = qc >= 3'h4;
  a_pready_high: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (psel && penable && paddr[11:4] != 8'h0B |-> pslverr)
    else $error("no error on unmapped access");
  a_alt_update: assert property (wr && paddr == 12'h0B4 |=> alt_gate_cfg ==
    {$past(pwdata[13]), $past(pwdata[11:7]), $past(pwdata[0])}) else $error("alt cfg");
  a_off_no_edge: assert property (q && md[1:0] == 2'h0 |-> !gate_edge)
    else $error("edge with gating off");
  a_rise_level: assert property (q && md[2:0] == 3'h2 && gate_edge |->
    $past(direction_gate) || direction_gate) else $error("rise edge wrong");
  a_fall_level: assert property (q && md[1:0] == 2'h3 && gate_edge |->
    !$past(direction_gate) || !direction_gate) else $error("fall edge wrong");
  a_edge_toggle: assert property (q && arm && !md[4] && md[6:5] == 2'h0 && md[1] &&
    gate_edge |-> count_enable != $past(count_enable)) else $error("edge did not toggle");
  a_start_only: assert property (q && arm && md[4:3] == 2'h2 && md[1] && gate_edge
    |-> count_enable) else $error("edge did not start");
  a_none_hold: assert property (q && md[4:3] == 2'h3 && gate_edge && !$past(terminal_count)
    |-> $stable(count_enable)) else $error("edge changed counting");
  a_tc_stop: assert property (count_enable && terminal_count && md[6:5] == 2'h1
    |-> ##[1:2] !count_enable) else $error("terminal count did not stop");
  c_edge: cover property (gate_edge && count_enable);
  c_tc: cover property (terminal_count && count_enable);
  c_err: cover property (psel && penable && pslverr);
endmodule

bind cgm_gate_mode_logic cgm_gate_mode_logic_monitor i_cgm_gate_mode_logic_monitor (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .gate_in(gate_in), .terminal_count(terminal_count), .count_enable(count_enable),
  .gate_edge(gate_edge), .direction_gate(direction_gate), .alt_gate_cfg(alt_gate_cfg));

// >>> cgm_gate_src.sv
// Selected gate and counter source: both leave from flops, as a synchronous source drives them.
module cgm_gate_src (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic g_req,
  input  wire logic tc_req,
  output logic      gate_in,
  output logic      terminal_count
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_in        <= 1'b0;
      terminal_count <= 1'b0;
    end else begin
      gate_in        <= g_req;
      terminal_count <= tc_req;
    end
  end
endmodule

// >>> cgm_gate_mode_logic_tb.sv
module cgm_gate_mode_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic                   g_req, tc_req, gate_in, terminal_count;
  logic                   count_enable, gate_edge, direction_gate;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, rd;
  cgm_pkg::cgm_alt_gate_t alt_gate_cfg;
  int                     err_count, tests_run;

  cgm_gate_mode_logic i_cgm_gate_mode_logic (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .gate_in(gate_in), .terminal_count(terminal_count),
    .count_enable(count_enable), .gate_edge(gate_edge), .direction_gate(direction_gate),
    .alt_gate_cfg(alt_gate_cfg));
  cgm_gate_src i_cgm_gate_src (.pclk(pclk), .presetn(presetn), .g_req(g_req),
    .tc_req(tc_req), .gate_in(gate_in), .terminal_count(terminal_count));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ce(input logic exp);
    chk({31'h0, count_enable}, {31'h0, exp});
  endtask
  task automatic gs(input logic g, input logic exp);
    g_req <= g;
    repeat (6) @(posedge pclk);
    ce(exp);
  endtask
  task automatic tc(input logic exp);
    tc_req <= 1'b1;
    @(posedge pclk);
    tc_req <= 1'b0;
    repeat (5) @(posedge pclk);
    ce(exp);
  endtask
  // Disarms, programs a legal mode with the gate low, then arms.
  task automatic cfg(input logic [15:0] m);
    g_req <= 1'b0;
    xfer(1'b1, 12'h0BC, 16'h0002);
    xfer(1'b1, 12'h0B0, m);
    xfer(1'b1, 12'h0BC, 16'h0001);
    repeat (6) @(posedge pclk);
  endtask

  task automatic t_regs;
    logic [15:0] d;
    d = 16'h2F81;
    xfer(1'b1, 12'h0B4, d);
    // The write lands at the access edge, so look one edge later.
    @(posedge pclk);
    chk({25'h0, alt_gate_cfg}, {25'h0, d[13], d[11:7], d[0]});
    xfer(1'b0, 12'h0B4, 16'h0000);
    chk(rd, 32'h00000000);
    xfer(1'b0, 12'h0B0, 16'h0000);
    chk(rd, 32'h00000000);
    xfer(1'b0, 12'h0C0, 16'h0000);
    chk({31'h0, er}, 32'h00000001);
  endtask
  task automatic t_etb0;
    cfg(16'h0002);
    ce(1'b0);
    gs(1'b1, 1'b1);
    gs(1'b0, 1'b1);
    gs(1'b1, 1'b0);
  endtask
  task automatic t_etb1;
    cfg(16'h000A);
    ce(1'b1);
    gs(1'b1, 1'b0);
    gs(1'b0, 1'b0);
    gs(1'b1, 1'b1);
  endtask
  task automatic t_etb2;
    cfg(16'h0032);
    gs(1'b1, 1'b1);
    gs(1'b0, 1'b1);
    gs(1'b1, 1'b1);
    tc(1'b0);
    gs(1'b0, 1'b0);
    gs(1'b1, 1'b1);
    cfg(16'h0052);
    gs(1'b1, 1'b1);
    tc(1'b1);
    // Status: counting, armed, gate level high and one terminal count seen.
    xfer(1'b0, 12'h0B8, 16'h0000);
    chk(rd, 32'h0000000F);
    tc(1'b0);
  endtask
  task automatic t_etb3;
    cfg(16'h001A);
    ce(1'b1);
    gs(1'b1, 1'b1);
    gs(1'b0, 1'b1);
  endtask
  task automatic t_edges;
    cfg(16'h0006);
    gs(1'b1, 1'b1);
    gs(1'b0, 1'b0);
    cfg(16'h0003);
    gs(1'b1, 1'b0);
    gs(1'b0, 1'b1);
    cfg(16'h2002);
    gs(1'b1, 1'b0);
    gs(1'b0, 1'b1);
    cfg(16'h0001);
    gs(1'b1, 1'b1);
    gs(1'b0, 1'b0);
  endtask
  task automatic t_off;
    // Gating off is only legal together with behaviour 3.
    cfg(16'h0018);
    ce(1'b1);
    gs(1'b1, 1'b1);
    chk({31'h0, direction_gate}, 32'h00000001);
    gs(1'b0, 1'b1);
  endtask

  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    stop_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, g_req, tc_req} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    err_count = 0;
    tests_run = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_etb0();
    t_etb1();
    t_etb2();
    t_etb3();
    t_edges();
    t_off();
    stop_test();
  end
endmodule
